// file: hw/ppt_consts.svh
`ifndef PPT_CONSTS_SVH
`define PPT_CONSTS_SVH
// ****************************************
// register offsets
// ****************************************
`define OFS_DATA 11'h000
`define OFS_STAT 11'h001
`define OFS_CTRL 11'h002
`define OFS_ASTR 11'h003
`define OFS_DSTR_LO 11'h004
`define OFS_DSTR_HI 11'h007
`define OFS_FIFO 11'h400
`define OFS_CFGB 11'h401
`define OFS_ECR 11'h402
// ****************************************
// fields and reset values
// ****************************************
`define CTL_DIR 5
`define CTL_ACKIE 4
`define CTL_SLI 3
`define CTL_INIT 2
`define CTL_AFD 1
`define CTL_STB 0
`define CTRL_RST 8'h00
`define ECR_RST 8'h00
`define CFGA_VAL 8'h10
`define CFGB_VAL 8'h00
`define PIN_W 13
// ****************************************
// mode encodings
// ****************************************
`define PM_EPP17 3'h2
`define PM_EPP19 3'h3
`define PM_ECP 3'h4
`define EM_ISA 3'h0
`define EM_PS2 3'h1
`define EM_SPP 3'h2
`define EM_ECP 3'h3
`define EM_TEST 3'h6
`define EM_CFG 3'h7
// ****************************************
// timing
// ****************************************
`define CLK_NS 20
`define TMO_NS 10000
`define TMO_CYC ((`TMO_NS) / (`CLK_NS))
`endif

// file: hw/ppt_pkg.sv
package ppt_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_HI, ST_WAIT_LO} xfer_st_e;
   typedef struct packed {
      logic write;
      logic [10:0] addr;
      logic [7:0] wdata;
   } host_req_s;
   typedef struct packed {
      logic cmd;
      logic [7:0] data;
   } ecp_byte_s;
   typedef struct packed {
      logic ack_n;
      logic busy;
      logic pe;
      logic slct;
      logic error_n;
      logic [7:0] pd;
   } pin_in_s;
endpackage

// file: hw/parallel_port_epp_ecp_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "ppt_consts.svh"
module parallel_port_epp_ecp_regs (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic port_enable,
   input wire logic [2:0] port_mode,
   input wire logic req_valid,
   input wire ppt_pkg::host_req_s req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   input wire ppt_pkg::pin_in_s pins_in,
   output logic [7:0] pd_out,
   output logic pd_oe,
   output logic strobe_n,
   output logic autofd_n,
   output logic select_in_n,
   output logic init_n,
   output logic ack_irq
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [`PIN_W-1:0] s1_q, s2_q, s3_q, flt_q;
   ppt_pkg::pin_in_s pin_q;
   always_ff @(posedge sys_clk) begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end
   for (genvar i = 0; i < `PIN_W; i++) begin : g_flt
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            flt_q[i] <= 1'b0;
         end else if (s2_q[i] == s3_q[i]) begin
            flt_q[i] <= s3_q[i];
         end
      end
   end
   assign pin_q = ppt_pkg::pin_in_s'(flt_q);

   // ****************************************
   // decode
   // ****************************************
   function automatic logic at(input logic [10:0] a, input logic [10:0] o);
      at = (a == o);
   endfunction

   logic [7:0] ctrl_q, ecr_q, data_q, cap_q, rsp_q;
   logic req_ready_q, rsp_valid_q, epp_act_q, tmo_q, epp_on_q, ack_prev_q, irq_q;
   logic pd_oe_q, init_n_q, stb_n_q, afd_n_q, sli_n_q, xfer_cmd_q;
   logic [7:0] pd_out_q;
   ppt_pkg::host_req_s cmd_q;
   ppt_pkg::ecp_byte_s buf_q [2];
   logic wp_q, rp_q;
   logic [1:0] cnt_q;
   ppt_pkg::xfer_st_e st_q;
   logic [8:0] tmr_q;

   wire [2:0] em = ecr_q[7:5];
   wire [10:0] a = req.addr;
   wire take = req_valid & req_ready_q;
   wire epp_on = port_enable & (port_mode == `PM_EPP17 | port_mode == `PM_EPP19);
   wire ecp_on = port_enable & (port_mode == `PM_ECP);
   wire std_on = port_enable & ~epp_on & ~ecp_on;
   wire any_on = port_enable;
   wire lat_mode = epp_on | std_on | ecp_on & (em == `EM_ISA | em == `EM_PS2);
   wire hit_data = lat_mode & at(a, `OFS_DATA);
   wire hit_afifo = ecp_on & em == `EM_ECP & at(a, `OFS_DATA) & req.write;
   wire hit_stat = any_on & at(a, `OFS_STAT);
   wire hit_ctrl = any_on & at(a, `OFS_CTRL);
   wire hit_ecr = ecp_on & at(a, `OFS_ECR);
   wire hit_astr = epp_on & at(a, `OFS_ASTR);
   wire hit_dstr = epp_on & a >= `OFS_DSTR_LO & a <= `OFS_DSTR_HI;
   wire at_fifo = ecp_on & at(a, `OFS_FIFO);
   wire hit_dfifo = at_fifo & req.write & (em == `EM_SPP | em == `EM_ECP);
   wire hit_cfga = at_fifo & em == `EM_CFG & ~req.write;
   wire hit_cfgb = ecp_on & at(a, `OFS_CFGB) & em == `EM_CFG & ~req.write;
   wire strobe_hit = hit_astr | hit_dstr;
   wire push = take & (hit_afifo | hit_dfifo);
   wire rev = ctrl_q[`CTL_DIR] & ~(ecp_on & (em == `EM_ISA | em == `EM_SPP));
   wire xmit_mode = ecp_on & (em == `EM_SPP | em == `EM_ECP);

   // ****************************************
   // read data
   // ****************************************
   wire [7:0] stat_v = {~pin_q.busy, pin_q.ack_n, pin_q.pe, pin_q.slct, pin_q.error_n,
                        1'b1, 1'b0, tmo_q & epp_on};
   wire [7:0] ctrl_v = epp_on ? {2'b00, ctrl_q[5:4], ~sli_n_q, ctrl_q[2], ~afd_n_q, ~stb_n_q}
                              : ctrl_q;
   wire [7:0] ecr_v = {ecr_q[7:2], cnt_q == 2'd2, cnt_q == 2'd0};
   wire [7:0] rd_mux = hit_data ? (rev ? pin_q.pd : data_q) :
                       hit_stat ? stat_v :
                       hit_ctrl ? ctrl_v :
                       hit_ecr ? ecr_v :
                       hit_cfga ? `CFGA_VAL :
                       hit_cfgb ? `CFGB_VAL : 8'h00;

   // ****************************************
   // two-entry output buffer
   // ****************************************
   logic pop;
   wire [1:0] cnt_d = cnt_q + 2'(push) - 2'(pop);
   wire ecp_go = xmit_mode & cnt_q != 2'd0 & ~ctrl_q[`CTL_DIR];
   wire ppt_pkg::ecp_byte_s head = buf_q[rp_q];
   wire ppt_pkg::ecp_byte_s in_byte = '{cmd: hit_afifo, data: req.wdata};
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'd0;
      end else begin
         if (push) begin
            buf_q[wp_q] <= in_byte;
            wp_q <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_d;
      end
   end

   // ****************************************
   // handshake engine
   // ****************************************
   ppt_pkg::xfer_st_e st_d;
   logic stb_d, afd_d, sli_d, tmo_set, done, xfer_cmd_d;
   logic [7:0] pdo_d, cap_d;
   logic [8:0] tmr_d;
   wire tmo_hit = tmr_q == 9'(`TMO_CYC - 1);
   wire addr_cyc = at(cmd_q.addr, `OFS_ASTR);
   wire idle_stb = (epp_on | xmit_mode) ? 1'b1 : ~ctrl_q[`CTL_STB];
   wire idle_afd = (epp_on | xmit_mode) ? 1'b1 : ~ctrl_q[`CTL_AFD];
   wire idle_sli = epp_on ? 1'b1 : ~ctrl_q[`CTL_SLI];

   always_comb begin
      st_d = st_q;
      stb_d = stb_n_q;
      afd_d = afd_n_q;
      sli_d = sli_n_q;
      pdo_d = pd_out_q;
      cap_d = cap_q;
      tmr_d = 9'd0;
      tmo_set = 1'b0;
      done = 1'b0;
      pop = 1'b0;
      xfer_cmd_d = xfer_cmd_q;
      unique case (st_q)
         ppt_pkg::ST_IDLE: begin
            stb_d = idle_stb;
            afd_d = idle_afd;
            sli_d = idle_sli;
            pdo_d = data_q;
            if (epp_act_q) begin
               st_d = ppt_pkg::ST_WAIT_HI;
               stb_d = ~cmd_q.write;
               pdo_d = cmd_q.wdata;
               if (addr_cyc) begin
                  sli_d = 1'b0;
               end else begin
                  afd_d = 1'b0;
               end
            end else if (ecp_go) begin
               st_d = ppt_pkg::ST_WAIT_HI;
               pop = 1'b1;
               stb_d = 1'b0;
               afd_d = ~head.cmd;
               pdo_d = head.data;
               xfer_cmd_d = head.cmd;
            end
         end
         ppt_pkg::ST_WAIT_HI: begin
            tmr_d = tmr_q + 9'd1;
            if (pin_q.busy) begin
               st_d = ppt_pkg::ST_WAIT_LO;
               tmr_d = 9'd0;
               if (epp_act_q) begin
                  sli_d = 1'b1;
                  afd_d = 1'b1;
                  cap_d = pin_q.pd;
               end else begin
                  stb_d = 1'b1;
               end
            end else if (tmo_hit) begin
               st_d = ppt_pkg::ST_IDLE;
               tmo_set = epp_act_q;
               done = epp_act_q;
            end
         end
         ppt_pkg::ST_WAIT_LO: begin
            tmr_d = tmr_q + 9'd1;
            if (!pin_q.busy || tmo_hit) begin
               st_d = ppt_pkg::ST_IDLE;
               tmo_set = epp_act_q & pin_q.busy;
               done = epp_act_q;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= ppt_pkg::ST_IDLE;
         tmr_q <= 9'd0;
         cap_q <= 8'h00;
         xfer_cmd_q <= 1'b0;
         stb_n_q <= 1'b1;
         afd_n_q <= 1'b1;
         sli_n_q <= 1'b1;
         pd_out_q <= 8'h00;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         cap_q <= cap_d;
         xfer_cmd_q <= xfer_cmd_d;
         stb_n_q <= stb_d;
         afd_n_q <= afd_d;
         sli_n_q <= sli_d;
         pd_out_q <= pdo_d;
      end
   end

   // ****************************************
   // host registers and answers
   // ****************************************
   wire epp_act_d = (take & strobe_hit) | (epp_act_q & ~done);
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         req_ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_q <= 8'h00;
         epp_act_q <= 1'b0;
         cmd_q <= '0;
         ctrl_q <= `CTRL_RST;
         ecr_q <= `ECR_RST;
         data_q <= 8'h00;
      end else begin
         req_ready_q <= ~take & ~epp_act_d & (cnt_d != 2'd2);
         rsp_valid_q <= (take & ~strobe_hit) | done;
         epp_act_q <= epp_act_d;
         if (take) begin
            rsp_q <= req.write ? 8'h00 : rd_mux;
         end else if (done) begin
            rsp_q <= cmd_q.write ? 8'h00 : cap_q;
         end
         if (take & strobe_hit) begin
            cmd_q <= req;
         end
         if (take & req.write & hit_ctrl) begin
            ctrl_q <= {2'b00, req.wdata[5:0]};
         end
         if (take & req.write & hit_ecr) begin
            ecr_q <= {req.wdata[7:2], 2'b00};
         end
         if (take & req.write & hit_data) begin
            data_q <= req.wdata;
         end
      end
   end

   // ****************************************
   // pins, timeout flag, ack interrupt
   // ****************************************
   wire ack_fell = ack_prev_q & ~pin_q.ack_n;
   wire stat_rd = take & hit_stat & ~req.write;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tmo_q <= 1'b0;
         epp_on_q <= 1'b0;
         ack_prev_q <= 1'b0;
         irq_q <= 1'b0;
         pd_oe_q <= 1'b0;
         init_n_q <= 1'b0;
      end else begin
         epp_on_q <= epp_on;
         if (tmo_set) begin
            tmo_q <= 1'b1;
         end else if (stat_rd | (epp_on & ~epp_on_q)) begin
            tmo_q <= 1'b0;
         end
         ack_prev_q <= pin_q.ack_n;
         irq_q <= ctrl_q[`CTL_ACKIE] & ack_fell;
         pd_oe_q <= ~rev;
         init_n_q <= ctrl_q[`CTL_INIT];
      end
   end

   assign req_ready = req_ready_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_rdata = rsp_q;
   assign pd_out = pd_out_q;
   assign pd_oe = pd_oe_q;
   assign strobe_n = stb_n_q;
   assign autofd_n = afd_n_q;
   assign select_in_n = sli_n_q;
   assign init_n = init_n_q;
   assign ack_irq = irq_q;

   // ****************************************
   // checks
   // ****************************************
   pd_dir_a: assert property (@(posedge sys_clk) disable iff (srst)
      $past(epp_on) && $past(ctrl_q[5]) && !srst |-> !pd_oe) else $error("pd driven in reverse");
   ack_irq_a: assert property (@(posedge sys_clk) disable iff (srst)
      ack_irq |-> $past(ctrl_q[4]) && $past(ack_prev_q) && !$past(pin_q.ack_n))
      else $error("ack interrupt without cause");
   init_pin_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 init_n == $past(ctrl_q[2])) else $error("init pin wrong");
   stb_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      take && hit_ctrl && !req.write && epp_on |=> rsp_valid && rsp_rdata[0] == !$past(strobe_n))
      else $error("strobe bit not inverse of pin");
   astr_cyc_a: assert property (@(posedge sys_clk) disable iff (srst)
      take && hit_astr && st_q == ppt_pkg::ST_IDLE |-> ##2 !select_in_n && autofd_n)
      else $error("no address strobe");
   dstr_cyc_a: assert property (@(posedge sys_clk) disable iff (srst)
      take && hit_dstr && st_q == ppt_pkg::ST_IDLE |-> ##2 !autofd_n && select_in_n)
      else $error("no data strobe");
   ecp_afd_a: assert property (@(posedge sys_clk) disable iff (srst)
      st_q != ppt_pkg::ST_IDLE && !epp_act_q |-> autofd_n == !xfer_cmd_q)
      else $error("autofeed does not mark byte kind");
   fifo_push_a: assert property (@(posedge sys_clk) disable iff (srst)
      push && !pop |=> cnt_q == $past(cnt_q) + 2'd1) else $error("byte not queued");
   tmo_clr_a: assert property (@(posedge sys_clk) disable iff (srst)
      stat_rd && !tmo_set |=> !tmo_q) else $error("timeout flag not cleared");
   sli_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      take && hit_ctrl && !req.write && epp_on |=> rsp_rdata[3] == !$past(select_in_n))
      else $error("select-in bit not inverse of pin");
   afd_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      take && hit_ctrl && !req.write && epp_on |=> rsp_rdata[1] == !$past(autofd_n))
      else $error("autofeed bit not inverse of pin");
   irq_off_a: assert property (@(posedge sys_clk) disable iff (srst)
      !ctrl_q[4] |=> !ack_irq) else $error("ack interrupt while disabled");
   dstr_alias_a: assert property (@(posedge sys_clk) disable iff (srst)
      take && epp_on && req.addr[10:2] == 9'h001 && st_q == ppt_pkg::ST_IDLE |-> ##2 !autofd_n && select_in_n)
      else $error("data strobe alias missed");
   ecr_silent_a: assert property (@(posedge sys_clk) disable iff (srst)
      take && !req.write && req.addr == `OFS_ECR && !ecp_on |=> rsp_valid && rsp_rdata == 8'h00)
      else $error("extended control answered outside ECP");
   cfg_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      take && hit_cfga |=> rsp_valid && rsp_rdata == `CFGA_VAL) else $error("configuration A not returned");
   ecp_data_a: assert property (@(posedge sys_clk) disable iff (srst)
      st_q == ppt_pkg::ST_IDLE && !epp_act_q && ecp_go |=> !strobe_n && pd_out == $past(head.data))
      else $error("queued byte not on data lines");
   buf_full_a: assert property (@(posedge sys_clk) disable iff (srst)
      cnt_q == 2'd2 |-> !req_ready) else $error("request taken into full buffer");
   tmo_set_a: assert property (@(posedge sys_clk) disable iff (srst)
      st_q == ppt_pkg::ST_WAIT_HI && epp_act_q && tmo_hit && !pin_q.busy |=> tmo_q)
      else $error("timeout flag not set");
endmodule
`default_nettype wire

// file: verif/peripheral_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// peripheral side of the port
// ****************************************
module peripheral_model (
   input wire logic sys_clk,
   input wire logic ecp,
   input wire logic mute,
   input wire logic [9:0] dly,
   input wire logic [7:0] rd_byte,
   input wire logic strobe_n,
   input wire logic autofd_n,
   input wire logic select_in_n,
   input wire logic [7:0] pd_out,
   output logic busy,
   output logic [7:0] pd_drv
);
   logic [9:0] cap [0:15];
   int ncap = 0;
   int cnt = 0;
   logic [7:0] pat = 8'h00;
   wire logic act = ecp ? ~strobe_n : (~autofd_n | ~select_in_n);
   initial busy = 1'b0;
   // busy follows the strobe dly+1 cycles after it changes
   always @(posedge sys_clk) begin
      pat <= pat + 8'h3b;
      if (mute || act == busy) begin
         cnt <= 0;
      end else if (cnt < int'(dly)) begin
         cnt <= cnt + 1;
      end else begin
         busy <= act;
         cnt <= 0;
         if (act) begin
            cap[ncap[3:0]] <= {autofd_n, select_in_n, pd_out};
            ncap <= ncap + 1;
         end
      end
   end
   // released lines show a moving pattern
   assign pd_drv = (act | busy) ? rd_byte : pat;
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   // ****************************************
   // signals
   // ****************************************
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic port_enable = 1'b0;
   logic [2:0] port_mode = 3'h0;
   logic req_valid = 1'b0;
   ppt_pkg::host_req_s req = '0;
   logic ack_n = 1'b1;
   logic ecp = 1'b0;
   logic mute = 1'b0;
   logic [9:0] dly = 10'h002;
   logic [7:0] rd_byte = 8'h00;
   wire logic req_ready, rsp_valid, pd_oe, strobe_n, autofd_n, select_in_n, init_n, ack_irq, busy;
   wire logic [7:0] rsp_rdata, pd_out, pd_drv;
   wire ppt_pkg::pin_in_s pins = {ack_n, busy, 1'b0, 1'b1, 1'b1, pd_oe ? pd_out : pd_drv};
   int n_mismatch = 0;
   int tests_run = 0;
   int n_rsp = 0;
   int cyc = 0;
   int k, p, t;
   logic [31:0] seed = 32'h7c7225ac;
   logic [7:0] exp_q [$];
   logic [7:0] bb [0:4];
   always #10 sys_clk = ~sys_clk;
   parallel_port_epp_ecp_regs dut (.sys_clk(sys_clk), .srst(srst), .port_enable(port_enable),
      .port_mode(port_mode), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins_in(pins), .pd_out(pd_out), .pd_oe(pd_oe),
      .strobe_n(strobe_n), .autofd_n(autofd_n), .select_in_n(select_in_n), .init_n(init_n),
      .ack_irq(ack_irq));
   peripheral_model peri (.sys_clk(sys_clk), .ecp(ecp), .mute(mute), .dly(dly), .rd_byte(rd_byte),
      .strobe_n(strobe_n), .autofd_n(autofd_n), .select_in_n(select_in_n), .pd_out(pd_out),
      .busy(busy), .pd_drv(pd_drv));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] expv);
      tests_run++;
      if (seen !== expv) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, expv, seen);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic acc(input logic w, input logic [10:0] a, input logic [7:0] d, input logic [7:0] e);
      int n0;
      int w8;
      n0 = n_rsp;
      w8 = 0;
      tick(1);
      exp_q.push_back(w ? 8'h00 : e);
      req_valid = 1'b1;
      req = {w, a, d};
      while (req_ready !== 1'b1) tick(1);
      tick(1);
      req_valid = 1'b0;
      while (n_rsp == n0 && w8 < 2000) begin
         tick(1);
         w8++;
      end
      if (w8 == 2000) check("response", 10'h001, 10'h000);
   endtask
   task automatic waitcap(input int n);
      t = 0;
      while (peri.ncap < n && t < 5000) begin
         tick(1);
         t++;
      end
   endtask
   // ****************************************
   // response monitor and hang guard
   // ****************************************
   always @(posedge sys_clk) begin
      cyc++;
      if (rsp_valid === 1'b1) begin
         check("rsp_rdata", {2'b00, rsp_rdata}, {2'b00, exp_q.pop_front()});
         n_rsp++;
      end
      if (cyc == 60000) begin
         n_mismatch++;
         summarize;
      end
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      tick(10);
      srst = 1'b0;
      check("idle pins", {5'h00, pd_oe, strobe_n, autofd_n, select_in_n, init_n}, 10'h00e);
      port_enable = 1'b1;
      port_mode = 3'h3;
      acc(1'b1, 11'h002, 8'h04, 8'h00);
      tick(1);
      check("init_n", {9'h000, init_n}, 10'h001);
      acc(1'b0, 11'h002, 8'h00, 8'h04);
      acc(1'b1, 11'h002, 8'h00, 8'h00);
      tick(1);
      check("init_n", {9'h000, init_n}, 10'h000);
      check("pd_oe", {9'h000, pd_oe}, 10'h001);
      for (k = 3; k < 8; k++) begin
         seed = xs(seed);
         p = peri.ncap;
         acc(1'b1, 11'(k), seed[7:0], 8'h00);
         check("epp byte", peri.cap[p[3:0]], {k == 3 ? 2'b10 : 2'b01, seed[7:0]});
      end
      acc(1'b1, 11'h002, 8'h20, 8'h00);
      tick(1);
      check("pd_oe", {9'h000, pd_oe}, 10'h000);
      for (k = 3; k < 5; k++) begin
         seed = xs(seed);
         rd_byte = seed[7:0];
         acc(1'b0, 11'(k), 8'h00, rd_byte);
      end
      acc(1'b1, 11'h002, 8'h00, 8'h00);
      mute = 1'b1;
      acc(1'b1, 11'h004, 8'h5a, 8'h00);
      mute = 1'b0;
      acc(1'b0, 11'h001, 8'h00, 8'hdd);
      acc(1'b0, 11'h001, 8'h00, 8'hdc);
      acc(1'b0, 11'h402, 8'h00, 8'h00);
      for (p = 1; p >= 0; p--) begin
         acc(1'b1, 11'h002, {3'h0, p[0], 4'h0}, 8'h00);
         k = 0;
         for (t = 0; t < 24; t++) begin
            ack_n = (t >= 12);
            tick(1);
            k += (ack_irq === 1'b1);
         end
         check("ack_irq", 10'(k), 10'(p));
      end
      acc(1'b1, 11'h002, 8'h00, 8'h00);
      port_mode = 3'h4;
      ecp = 1'b1;
      acc(1'b1, 11'h402, 8'h60, 8'h00);
      p = peri.ncap;
      acc(1'b1, 11'h000, 8'h85, 8'h00);
      acc(1'b1, 11'h400, 8'h05, 8'h00);
      waitcap(p + 2);
      check("ecp addr", peri.cap[p[3:0]], {2'b01, 8'h85});
      check("ecp data", peri.cap[4'(p + 1)], {2'b11, 8'h05});
      dly = 10'h064;
      p = peri.ncap;
      for (k = 0; k < 5; k++) begin
         seed = xs(seed);
         bb[k] = seed[7:0];
         acc(1'b1, 11'h000, bb[k], 8'h00);
      end
      dly = 10'h002;
      waitcap(p + 5);
      for (k = 0; k < 5; k++) check("buffered", peri.cap[4'(p + k)], {2'b01, bb[k]});
      acc(1'b0, 11'h402, 8'h00, 8'h61);
      acc(1'b1, 11'h402, 8'h40, 8'h00);
      p = peri.ncap;
      acc(1'b1, 11'h400, 8'hc3, 8'h00);
      waitcap(p + 1);
      check("spp fifo", peri.cap[p[3:0]], {2'b11, 8'hc3});
      acc(1'b1, 11'h402, 8'he0, 8'h00);
      acc(1'b0, 11'h400, 8'h00, 8'h10);
      acc(1'b0, 11'h401, 8'h00, 8'h00);
      acc(1'b0, 11'h000, 8'h00, 8'h00);
      acc(1'b1, 11'h402, 8'hc0, 8'h00);
      acc(1'b0, 11'h400, 8'h00, 8'h00);
      acc(1'b1, 11'h402, 8'h20, 8'h00);
      acc(1'b0, 11'h402, 8'h00, 8'h21);
      acc(1'b0, 11'h001, 8'h00, 8'hdc);
      acc(1'b1, 11'h002, 8'h20, 8'h00);
      tick(1);
      check("pd_oe ps2", {9'h000, pd_oe}, 10'h000);
      acc(1'b1, 11'h402, 8'h00, 8'h00);
      tick(1);
      check("pd_oe isa", {9'h000, pd_oe}, 10'h001);
      summarize;
   end
endmodule
`default_nettype wire
